// ---- hw/opp_pkg.sv ----
// Constants, timing and carrier types for the PROM programmer controller.
// Assumes a single 40 MHz clock domain and an external supply switch for the
// programming level, steered by the vpp_high output of the controller.
package opp_pkg;

   // =========================================================================
   // Geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 4;
   localparam int ARRAY_BYTES = 32768;
   localparam int MAX_TRIES = 10;

   // =========================================================================
   // Timing
   localparam int CLK_MHZ = 40;
   localparam int PULSE_NS = 100000;
   localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = 4;
   localparam int SAMPLE_CYC = 8;

   // =========================================================================
   // Commands
   typedef enum logic [1:0] {
      OPP_CMD_READ = 2'h0,
      OPP_CMD_BYTE = 2'h1,
      OPP_CMD_PAGE = 2'h2
   } opp_cmd_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W*PAGE_BYTES-1:0] data;
      opp_cmd_e cmd;
   } opp_req_s;

   typedef struct packed {
      logic [DATA_W*PAGE_BYTES-1:0] data;
      logic fail;
      logic [3:0] tries;
   } opp_rsp_s;

   // Pin reset levels: all strobes inactive, data released.
   localparam logic PIN_IDLE = 1'b1;

endpackage

// ---- hw/opp_sync.sv ----
// Two-flip-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module opp_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // opp_sync
`default_nettype wire

// ---- hw/opp_prom_programmer.sv ----
// PROM programmer controller: drives mode, supply, strobe, address and data
// pins of the one-time PROM, with read, byte program and page program.
// Assumes the supply switch settles within SETUP_CYC cycles of vpp_high.
`timescale 1ns/1ps
`default_nettype none
module opp_prom_programmer #(
   parameter int PULSE_CYCLES = opp_pkg::PULSE_CYC,
   parameter int TRIES = opp_pkg::MAX_TRIES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Request side
   input wire logic req_valid,
   input wire opp_pkg::opp_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output opp_pkg::opp_rsp_s rsp,
   // PROM pins
   output logic mode_select_low,
   output logic mode_select_high,
   output logic vpp_high,
   output logic chip_enable_n,
   output logic output_gate_n,
   output logic program_strobe_n,
   output logic [opp_pkg::ADDR_W-1:0] prom_address_bus,
   input wire logic [opp_pkg::DATA_W-1:0] prom_data_in,
   output logic [opp_pkg::DATA_W-1:0] prom_data_out,
   output logic prom_data_oe_n
);
   localparam int DW = opp_pkg::DATA_W;
   localparam int CW = $clog2(PULSE_CYCLES + 1) + 1;

   initial begin
      if (PULSE_CYCLES < 1 || TRIES < 1 || TRIES > 15) begin
         $error("opp_prom_programmer: bad parameter");
      end
   end

   // =========================================================================
   // Pin input synchroniser
   logic [DW-1:0] data_sync;

   opp_sync #(.WIDTH(DW)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .async_in(prom_data_in),
      .sync_out(data_sync)
   );

   // =========================================================================
   // Sequencer
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_SETUP = 7'h02,
      ST_LATCH = 7'h04,
      ST_PULSE = 7'h08,
      ST_VERIFY = 7'h10,
      ST_SAMPLE = 7'h20,
      ST_DONE = 7'h40
   } opp_state_e;

   opp_state_e state_reg;
   opp_pkg::opp_req_s job_reg;
   logic [CW-1:0] cnt_reg;
   logic [1:0] idx_reg;
   logic [3:0] tries_reg;
   logic mismatch_reg;
   logic [DW*opp_pkg::PAGE_BYTES-1:0] got_reg;

   function automatic logic [DW-1:0] pick_byte(input logic [DW*4-1:0] w, input logic [1:0] i);
      pick_byte = w[i*DW +: DW];
   endfunction

   logic is_prog;
   logic is_page;
   assign is_prog = (job_reg.cmd != opp_pkg::OPP_CMD_READ);
   assign is_page = (job_reg.cmd == opp_pkg::OPP_CMD_PAGE);

   logic [1:0] last_idx;
   assign last_idx = is_page ? 2'h3 : 2'h0;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         job_reg <= '0;
         cnt_reg <= '0;
         idx_reg <= 2'h0;
         tries_reg <= 4'h0;
         mismatch_reg <= 1'b0;
         got_reg <= '0;
      end else if (clk_en) begin
         case (state_reg)
            ST_IDLE: begin
               if (req_valid) begin
                  job_reg <= req;
                  cnt_reg <= CW'(opp_pkg::SETUP_CYC);
                  idx_reg <= 2'h0;
                  tries_reg <= 4'h0;
                  mismatch_reg <= 1'b0;
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_reg == '0) begin
                  cnt_reg <= CW'(opp_pkg::SAMPLE_CYC);
                  if (is_page) begin
                     state_reg <= ST_LATCH;
                  end else if (is_prog) begin
                     cnt_reg <= CW'(PULSE_CYCLES);
                     state_reg <= ST_PULSE;
                  end else begin
                     state_reg <= ST_SAMPLE;
                  end
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ST_LATCH: begin
               if (cnt_reg == '0) begin
                  cnt_reg <= CW'(opp_pkg::SAMPLE_CYC);
                  if (idx_reg == 2'h3) begin
                     idx_reg <= 2'h0;
                     cnt_reg <= CW'(PULSE_CYCLES);
                     state_reg <= ST_PULSE;
                  end else begin
                     idx_reg <= idx_reg + 1'b1;
                  end
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ST_PULSE: begin
               if (cnt_reg == '0) begin
                  tries_reg <= tries_reg + 1'b1;
                  mismatch_reg <= 1'b0;
                  idx_reg <= 2'h0;
                  cnt_reg <= CW'(opp_pkg::SAMPLE_CYC);
                  state_reg <= ST_VERIFY;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ST_VERIFY: begin
               if (cnt_reg == '0) begin
                  got_reg[idx_reg*DW +: DW] <= data_sync;
                  cnt_reg <= CW'(opp_pkg::SAMPLE_CYC);
                  if (data_sync != pick_byte(job_reg.data, idx_reg)) begin
                     mismatch_reg <= 1'b1;
                  end
                  if (idx_reg == last_idx) begin
                     if ((mismatch_reg || data_sync != pick_byte(job_reg.data, idx_reg))
                         && tries_reg < 4'(TRIES)) begin
                        idx_reg <= 2'h0;
                        state_reg <= is_page ? ST_LATCH : ST_PULSE;
                        if (!is_page) begin
                           cnt_reg <= CW'(PULSE_CYCLES);
                        end
                     end else begin
                        state_reg <= ST_DONE;
                     end
                  end else begin
                     idx_reg <= idx_reg + 1'b1;
                  end
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ST_SAMPLE: begin
               if (cnt_reg == '0) begin
                  got_reg <= {{(DW*3){1'b0}}, data_sync};
                  state_reg <= ST_DONE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // =========================================================================
   // Response and handshake
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else if (clk_en) begin
         req_ready <= (state_reg == ST_DONE) ||
                      (state_reg == ST_IDLE && !req_valid && !req_ready);
         rsp_valid <= (state_reg == ST_DONE);
         if (state_reg == ST_DONE) begin
            rsp.data <= got_reg;
            rsp.fail <= is_prog && mismatch_reg;
            rsp.tries <= tries_reg;
         end
      end
   end

   // =========================================================================
   // Pin drive. The program strobe only goes low while the elevated supply is applied,
   // so a read-level job can never disturb the array.
   logic busy;
   assign busy = (state_reg != ST_IDLE) && (state_reg != ST_DONE);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_select_low <= 1'b0;
         mode_select_high <= 1'b0;
         vpp_high <= 1'b0;
         chip_enable_n <= opp_pkg::PIN_IDLE;
         output_gate_n <= opp_pkg::PIN_IDLE;
         program_strobe_n <= opp_pkg::PIN_IDLE;
         prom_address_bus <= '0;
         prom_data_out <= '0;
         prom_data_oe_n <= opp_pkg::PIN_IDLE;
      end else if (clk_en) begin
         mode_select_low <= busy;
         mode_select_high <= busy;
         vpp_high <= busy && is_prog;
         prom_address_bus <= job_reg.addr + {15'h0, idx_reg};
         prom_data_out <= pick_byte(job_reg.data, idx_reg);
         case (state_reg)
            ST_LATCH: begin
               // enable high, gate low, strobe high, data driven
               chip_enable_n <= 1'b1;
               output_gate_n <= 1'b0;
               program_strobe_n <= 1'b1;
               prom_data_oe_n <= 1'b0;
            end
            ST_PULSE: begin
               // low pulse only at elevated supply
               chip_enable_n <= !(!is_page);
               output_gate_n <= 1'b1;
               program_strobe_n <= !(is_prog && vpp_high);
               prom_data_oe_n <= is_page;
            end
            ST_VERIFY, ST_SAMPLE: begin
               // enable low, gate low, strobe high, bus released
               chip_enable_n <= 1'b0;
               output_gate_n <= 1'b0;
               program_strobe_n <= 1'b1;
               prom_data_oe_n <= 1'b1;
            end
            default: begin
               chip_enable_n <= 1'b1;
               output_gate_n <= 1'b1;
               program_strobe_n <= 1'b1;
               prom_data_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // =========================================================================
   // Checks
   strobe_needs_vpp_a: assert property (@(posedge clk) disable iff (!rst_b)
      !program_strobe_n |-> vpp_high)
      else $error("strobe low without elevated supply");
   no_drive_read_a: assert property (@(posedge clk) disable iff (!rst_b)
      !output_gate_n |-> (prom_data_oe_n || chip_enable_n))
      else $error("bus contention while device drives");
   tries_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
      rsp_valid |-> rsp.tries <= 4'(TRIES))
      else $error("too many attempts");
   mode_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
      !chip_enable_n |-> (mode_select_low && mode_select_high))
      else $error("access outside PROM mode");
   page_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!prom_data_oe_n && !output_gate_n) |-> (chip_enable_n && program_strobe_n && vpp_high))
      else $error("data driven with gate low outside page latch");
   idle_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
      !mode_select_high |-> (chip_enable_n && program_strobe_n && prom_data_oe_n))
      else $error("pins active outside PROM mode");
   cover_read_c: cover property (@(posedge clk) rsp_valid && !rsp.fail && rsp.tries == 4'h0);
   cover_retry_c: cover property (@(posedge clk) rsp_valid && rsp.tries > 4'h1);
   cover_fail_c: cover property (@(posedge clk) rsp_valid && rsp.fail);
endmodule // opp_prom_programmer
`default_nettype wire

// ---- bench/opp_prom_model.sv ----
// Behavioural model of the one-time PROM as seen at its programming pins.
// Assumes the bench resolves the shared data line and feeds it back here.
`timescale 1ns/1ps
`default_nettype none
module opp_prom_model (
   // Clock
   input wire logic clk,
   // Mode and supply
   input wire logic mode_select_low,
   input wire logic mode_select_high,
   input wire logic vpp_high,
   // Strobes
   input wire logic chip_enable_n,
   input wire logic output_gate_n,
   input wire logic program_strobe_n,
   // Address and data
   input wire logic [opp_pkg::ADDR_W-1:0] prom_address_bus,
   input wire logic [opp_pkg::DATA_W-1:0] data_line,
   output logic [opp_pkg::DATA_W-1:0] data_out,
   output logic data_drive,
   // Fault control: pulses below this count are ignored
   input wire logic [7:0] skip_pulses
);
   logic [7:0] mem [0:opp_pkg::ARRAY_BYTES-1];
   logic [7:0] page_buf [0:3];
   logic [7:0] pulses;
   logic [opp_pkg::ADDR_W-1:0] hold_a;
   logic [7:0] hold_d;
   logic hold_ce, armed, access;
   // =========================================================================
   // Read side
   // access entry
   assign access = mode_select_low && mode_select_high;
   // drive only in read or verify
   assign data_drive = access && !chip_enable_n && !output_gate_n && program_strobe_n;
   assign data_out = data_drive ? mem[prom_address_bus[14:0]] : 8'h00;
   initial begin
      for (int i = 0; i < opp_pkg::ARRAY_BYTES; i++) mem[i] = 8'hFF;
      pulses = 8'h00;
      armed = 1'b0;
   end
   // =========================================================================
   // Program side
   // page latch
   always @(posedge clk) begin
      if (access && vpp_high && chip_enable_n && !output_gate_n && program_strobe_n)
         page_buf[prom_address_bus[1:0]] = data_line;
   end
   // program when the strobe is released, never at read supply
   always @(posedge clk) begin
      if (!program_strobe_n) begin
         hold_a = prom_address_bus;
         hold_d = data_line;
         hold_ce = chip_enable_n;
         armed = access && vpp_high && output_gate_n;
      end else if (armed) begin
         armed = 1'b0;
         if (pulses >= skip_pulses) begin
            if (hold_ce)
               for (int i = 0; i < 4; i++) mem[{hold_a[14:2], 2'(i)}] = page_buf[i];
            else
               mem[hold_a[14:0]] = hold_d;
         end
         pulses = pulses + 8'h01;
      end
   end
endmodule // opp_prom_model
`default_nettype wire

// ---- bench/test_opp_prom_programmer.sv ----
// Self-checking bench for the PROM programmer controller.
// Assumes the PROM model beside it; shortens the program pulse to 9 cycles (PULSE_CYCLES of 8).
`timescale 1ns/1ps
`default_nettype none
module test_opp_prom_programmer;
   logic clk, rst_b, req_valid, rsp_valid, saw_vpp, saw_mode;
   opp_pkg::opp_req_s req;
   opp_pkg::opp_rsp_s rsp;
   logic mode_select_low, mode_select_high, vpp_high;
   logic chip_enable_n, output_gate_n, program_strobe_n;
   logic [opp_pkg::ADDR_W-1:0] prom_address_bus;
   logic [7:0] prom_data_out, data_line, model_data, last_line, skip_pulses, p0;
   logic prom_data_oe_n, model_drive, req_ready;
   int err_total, check_count, cycles;
   opp_prom_programmer #(.PULSE_CYCLES(8), .TRIES(10)) dut (.clk(clk), .rst_b(rst_b),
      .clk_en(1'b1), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid),
      .rsp(rsp), .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
      .vpp_high(vpp_high), .chip_enable_n(chip_enable_n), .output_gate_n(output_gate_n),
      .program_strobe_n(program_strobe_n), .prom_address_bus(prom_address_bus),
      .prom_data_in(data_line), .prom_data_out(prom_data_out),
      .prom_data_oe_n(prom_data_oe_n));
   opp_prom_model model (.clk(clk), .mode_select_low(mode_select_low),
      .mode_select_high(mode_select_high), .vpp_high(vpp_high),
      .chip_enable_n(chip_enable_n), .output_gate_n(output_gate_n),
      .program_strobe_n(program_strobe_n), .prom_address_bus(prom_address_bus),
      .data_line(data_line), .data_out(model_data), .data_drive(model_drive),
      .skip_pulses(skip_pulses));
   // A released line shows the inverse of its last level, so stale data never passes.
   assign data_line = !prom_data_oe_n ? prom_data_out : (model_drive ? model_data : ~last_line);
   always #12.5 clk = ~clk;
   // =========================================================================
   // Monitors
   always @(posedge clk) begin
      last_line <= data_line;
      cycles++;
      if (model_drive === 1'b1 && prom_data_oe_n === 1'b0) begin
         $display("ERROR data line both drive expected 0 seen 1");
         err_total++;
      end
      if (cycles == 5000) begin
         $display("ERROR cycle ceiling expected 0 seen 1");
         err_total++;
         results();
      end
   end
   // =========================================================================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask
   task automatic job(input opp_pkg::opp_cmd_e c, input logic [16:0] a, input logic [31:0] d);
      int n;
      n = 0;
      saw_vpp = 1'b0;
      saw_mode = 1'b0;
      @(posedge clk);
      #1;
      req = '{addr: a, data: d, cmd: c};
      req_valid = 1'b1;
      do begin
         @(posedge clk);
         #1;
         n++;
         saw_vpp |= (vpp_high === 1'b1);
         saw_mode |= (mode_select_low === 1'b1 && mode_select_high === 1'b1);
      end while (rsp_valid !== 1'b1 && n < 3000);
      req_valid = 1'b0;
      chk("answer wait", 32'h1, 32'(n < 3000));
      chk("ready with answer", 32'h1, 32'(req_ready === 1'b1));
      chk("mode pins", 32'h1, 32'(saw_mode));
      chk("supply level", 32'(c != opp_pkg::OPP_CMD_READ), 32'(saw_vpp));
   endtask
   task automatic rd(input logic [16:0] a, input logic [7:0] exp);
      job(opp_pkg::OPP_CMD_READ, a, 32'h0);
      chk("read byte", 32'(exp), 32'(rsp.data[7:0]));
   endtask
   task automatic prog(input opp_pkg::opp_cmd_e c, input logic [16:0] a, input logic [31:0] d,
                       input logic fail, input logic [3:0] tries);
      job(c, a, d);
      chk("fail flag", 32'(fail), 32'(rsp.fail));
      chk("tries", 32'(tries), 32'(rsp.tries));
   endtask
   // =========================================================================
   // Scenarios
   task automatic test_reset;
      chk("reset pins", 32'h1F, 32'({chip_enable_n, output_gate_n, program_strobe_n,
          prom_data_oe_n, ~(mode_select_high | mode_select_low | vpp_high)}));
      $display("test reset done");
   endtask
   task automatic test_blank;
      rd(17'h00040, 8'hFF);
      $display("test blank read done");
   endtask
   task automatic test_byte;
      prog(opp_pkg::OPP_CMD_BYTE, 17'h00123, 32'h000000A5, 1'b0, 4'h1);
      rd(17'h00123, 8'hA5);
      rd(17'h00122, 8'hFF);
      $display("test byte program done");
   endtask
   task automatic test_page;
      prog(opp_pkg::OPP_CMD_PAGE, 17'h00200, 32'h44332211, 1'b0, 4'h1);
      for (int i = 0; i < 4; i++) rd(17'h00200 + 17'(i), 8'(8'h11 * (i + 1)));
      rd(17'h00204, 8'hFF);
      $display("test page program done");
   endtask
   task automatic test_retry;
      skip_pulses = model.pulses + 8'h02;
      prog(opp_pkg::OPP_CMD_BYTE, 17'h00300, 32'h0000005A, 1'b0, 4'h3);
      rd(17'h00300, 8'h5A);
      $display("test retry done");
   endtask
   task automatic test_exhaust;
      p0 = model.pulses;
      skip_pulses = p0 + 8'h14;
      prog(opp_pkg::OPP_CMD_BYTE, 17'h00310, 32'h0000003C, 1'b1, 4'hA);
      chk("pulse count", 32'hA, 32'(model.pulses - p0));
      rd(17'h00310, 8'hFF);
      $display("test exhaust done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      skip_pulses = 8'h00;
      last_line = 8'h00;
      err_total = 0;
      check_count = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      #1;
      test_reset();
      rst_b = 1'b1;
      test_blank();
      test_byte();
      test_page();
      test_retry();
      test_exhaust();
      results();
   end
endmodule // test_opp_prom_programmer
`default_nettype wire
